// *** design/lcd_pkg.sv ***
// Package of command codes, field positions, reset values and timing counts for the LCD command decoder
package lcd_pkg;
   // Clock rate and blink timing
   localparam int CLK_HZ = 125000000;
   localparam int BLINK_SLOW_MS = 1000;
   localparam int BLINK_FAST_MS = 500;
   localparam int BLINK_SLOW_CYC = CLK_HZ / 1000 * BLINK_SLOW_MS;
   localparam int BLINK_FAST_CYC = CLK_HZ / 1000 * BLINK_FAST_MS;
   // Full command codes
   localparam logic [7:0] CMD_DISP_OFF = 8'hAE;
   localparam logic [7:0] CMD_ADC = 8'hA0;
   localparam logic [7:0] CMD_BIAS = 8'hA2;
   localparam logic [7:0] CMD_ALLON = 8'hA4;
   localparam logic [7:0] CMD_INVERT = 8'hA6;
   localparam logic [7:0] CMD_IND = 8'hAC;
   localparam logic [7:0] CMD_RMW = 8'hE0;
   localparam logic [7:0] CMD_RST = 8'hE2;
   localparam logic [7:0] CMD_NOP = 8'hE3;
   localparam logic [7:0] CMD_END = 8'hEE;
   localparam logic [7:0] CMD_EPOT = 8'h81;
   // Prefix codes
   localparam logic [1:0] PFX_START = 2'h1;
   localparam logic [3:0] PFX_PAGE = 4'hB;
   localparam logic [3:0] PFX_COL_HI = 4'h1;
   localparam logic [3:0] PFX_COL_LO = 4'h0;
   localparam logic [4:0] PFX_PWR = 5'h05;
   localparam logic [4:0] PFX_RES = 5'h04;
   localparam logic [4:0] PFX_COM = 5'h18;
   localparam logic [4:0] PFX_DRIVE = 5'h1A;
   localparam logic [3:0] PFX_TEST = 4'hF;
   // Field positions
   localparam int BIT_SEL = 0;
   localparam int BIT_DIR = 3;
   // Reset values
   localparam logic [5:0] RST_START = 6'h00;
   localparam logic [3:0] RST_PAGE = 4'h0;
   localparam logic [7:0] RST_COL = 8'h00;
   localparam logic [2:0] RST_RES = 3'h0;
   localparam logic [5:0] RST_EPOT = 6'h20;
   localparam logic [1:0] RST_IND = 2'h0;
   localparam logic [4:0] RST_LINES = 5'h00;
   // Indicator modes
   localparam logic [1:0] IND_OFF = 2'h0;
   localparam logic [1:0] IND_SLOW = 2'h1;
   localparam logic [1:0] IND_FAST = 2'h2;
   localparam logic [1:0] IND_ON = 2'h3;
   // Decoder lock states, Gray in the order listed
   typedef enum logic [1:0] {
      LCD_FREE = 2'b00,
      LCD_WAIT_IND = 2'b01,
      LCD_WAIT_LINES = 2'b11,
      LCD_WAIT_EPOT = 2'b10
   } lcd_lock_t;
   // Power states
   typedef enum logic [1:0] {
      LCD_RUN = 2'b00,
      LCD_STANDBY = 2'b01,
      LCD_SLEEP = 2'b11
   } lcd_pwr_t;
endpackage

// *** design/lcd_sync.sv ***
// Two-flop synchroniser for a level from outside the clock domain
`timescale 1ns/100ps
`default_nettype none
module lcd_sync (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Level in and out
   input wire logic din,
   output logic dout
);
   logic meta_q;
   // First flop feeds only the second
   always_ff @(posedge clk) begin
      if (reset) begin
         meta_q <= 1'b0;
         dout <= 1'b0;
      end else begin
         meta_q <= din;
         dout <= meta_q;
      end
   end
endmodule
`default_nettype wire

// *** design/lcd_blink.sv ***
// Static indicator blink generator driven by a period in clock cycles
`timescale 1ns/100ps
`default_nettype none
module lcd_blink #(
   parameter int SLOW_CYC = 125000000,
   parameter int FAST_CYC = 62500000
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Mode and running enable
   input wire logic [1:0] mode,
   input wire logic run,
   // Indicator drive level
   output logic ind_on
);
   import lcd_pkg::*;
   logic [31:0] cnt_q;
   logic phase_q;
   logic [31:0] limit;
   assign limit = (mode == IND_SLOW) ? 32'(SLOW_CYC - 1) : 32'(FAST_CYC - 1);
   // Toggle phase at the end of each interval
   always_ff @(posedge clk) begin
      if (reset || !run || mode == IND_OFF || mode == IND_ON) begin
         cnt_q <= 32'h0;
         phase_q <= 1'b1;
      end else if (cnt_q >= limit) begin
         cnt_q <= 32'h0;
         phase_q <= ~phase_q;
      end else begin
         cnt_q <= cnt_q + 32'h1;
      end
   end
   // Indicator output level
   always_ff @(posedge clk) begin
      if (reset) begin
         ind_on <= 1'b0;
      end else begin
         ind_on <= run && (mode == IND_ON || (mode != IND_OFF && phase_q));
      end
   end
endmodule
`default_nettype wire

// *** design/lcd_cmd_decoder.sv ***
// Command decoder of a dot-matrix LCD driver: command, status and display data access
// Behaviour
// - Indicator register holds low two bits: off, slow blink, fast blink, steady
// - Drive method byte: D3 zero frame reversal, D3 one line reversal
// - After line reversal select, only the line count byte is accepted
// - Line count byte low five bits give one to thirty-two reversed lines
// - All-dots-on with D0 set while display off enters power save
// - Power save is standby with indicator enabled, sleep otherwise
// - Power save keeps memory and settings, host memory access still works
// - All-dots-on with D0 clear leaves power save
// - Sleep stops oscillator and supply, drive outputs held at ground
// - Standby stops supply and dynamic drive, oscillator and indicator run
// - Reset command in standby moves device into sleep
// - Upper nibble 1111 enters test only with test pin high; no-op exits
// - Select low read gives status nibble over zeros; select high reaches memory
// - Display on/off byte follows bit zero
// - Start line, page and column nibble address commands decode by prefix
// - Segment mapping forward or reverse by bit zero
// - Pixel polarity normal or inverted by bit zero
// - Show memory or force all dots on by bit zero
// - Bias ratio: bit zero clear higher ratio, set lower ratio
// - Read-modify-write: column advances on writes only; end byte restores column
// - Common scan direction forward or reverse by bit three
// - Supply circuit on/off and resistor ratio set by three-bit fields
// - After indicator enable, only the indicator register byte is accepted
`timescale 1ns/100ps
`default_nettype none
module lcd_cmd_decoder #(
   parameter int SLOW_CYC = lcd_pkg::BLINK_SLOW_CYC,
   parameter int FAST_CYC = lcd_pkg::BLINK_FAST_CYC,
   parameter int COL_W = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Host bus, one-cycle strobes
   input wire logic cmd_data_select,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic [7:0] wr_data,
   output logic [7:0] rd_data,
   output logic rd_valid,
   // Pin from outside the clock domain
   input wire logic factory_test_enable_pin,
   // Display memory port
   input wire logic [7:0] mem_rd_data,
   output logic mem_wr,
   output logic mem_rd,
   output logic [7:0] mem_wr_data,
   output logic [3:0] mem_page,
   output logic [COL_W-1:0] mem_col,
   // Display settings
   output logic display_on,
   output logic [5:0] start_line,
   output logic seg_reverse,
   output logic pixel_invert,
   output logic all_dots_on,
   output logic bias_low,
   output logic common_reverse,
   output logic line_reversal,
   output logic [5:0] reversed_lines,
   output logic [2:0] supply_ctrl,
   output logic [2:0] resistor_ratio,
   output logic [5:0] contrast,
   // Power, drive and test control
   output logic osc_enable,
   output logic supply_enable,
   output logic dynamic_drive_enable,
   output logic outputs_grounded,
   output logic standby,
   output logic sleep,
   output logic test_mode,
   // Static indicator
   output logic [1:0] indicator_mode,
   output logic indicator_drive
);
   import lcd_pkg::*;

   lcd_lock_t lock_q;
   lcd_pwr_t pwr_q;
   logic test_pin_s;
   logic ind_en_q;
   logic rmw_q;
   logic [COL_W-1:0] col_q;
   logic [COL_W-1:0] rmw_col_q;
   logic [4:0] lines_q;
   logic cmd_wr;
   logic [7:0] c;
   logic free;
   logic soft_rst;

   // Test pin crosses into the clock domain
   lcd_sync u_sync (
      .clk(clk),
      .reset(reset),
      .din(factory_test_enable_pin),
      .dout(test_pin_s)
   );

   // Indicator blink keeps running in standby, stops in sleep
   lcd_blink #(
      .SLOW_CYC(SLOW_CYC),
      .FAST_CYC(FAST_CYC)
   ) u_blink (
      .clk(clk),
      .reset(reset),
      .mode(indicator_mode),
      .run(ind_en_q && pwr_q != LCD_SLEEP),
      .ind_on(indicator_drive)
   );

   // Command strobe and decode qualifiers
   assign cmd_wr = wr_stb && !cmd_data_select;
   assign c = wr_data;
   assign free = cmd_wr && lock_q == LCD_FREE && !test_mode;
   assign soft_rst = free && c == CMD_RST;

   // Lock sequencer for two-byte commands
   always_ff @(posedge clk) begin
      if (reset) begin
         lock_q <= LCD_FREE;
      end else if (cmd_wr) begin
         unique case (lock_q)
            LCD_FREE: begin
               if (!test_mode && c == (CMD_IND | 8'h01)) begin
                  lock_q <= LCD_WAIT_IND;
               end else if (!test_mode && c[7:4] == PFX_DRIVE[4:1] && c[BIT_DIR]) begin
                  lock_q <= LCD_WAIT_LINES;
               end else if (!test_mode && c == CMD_EPOT) begin
                  lock_q <= LCD_WAIT_EPOT;
               end
            end
            LCD_WAIT_IND: lock_q <= LCD_FREE;
            LCD_WAIT_LINES: lock_q <= LCD_FREE;
            LCD_WAIT_EPOT: lock_q <= LCD_FREE;
         endcase
      end
   end

   // Second bytes of two-byte commands
   always_ff @(posedge clk) begin
      if (reset) begin
         indicator_mode <= RST_IND;
         lines_q <= RST_LINES;
         contrast <= RST_EPOT;
         ind_en_q <= 1'b0;
      end else if (cmd_wr && lock_q == LCD_WAIT_IND) begin
         indicator_mode <= c[1:0];
      end else if (cmd_wr && lock_q == LCD_WAIT_LINES) begin
         lines_q <= c[4:0];
      end else if (cmd_wr && lock_q == LCD_WAIT_EPOT) begin
         contrast <= c[5:0];
      end else if (soft_rst) begin
         indicator_mode <= RST_IND;
         contrast <= RST_EPOT;
         ind_en_q <= 1'b0;
      end else if (free && c[7:1] == CMD_IND[7:1]) begin
         ind_en_q <= c[BIT_SEL];
      end
   end
   assign reversed_lines = {1'b0, lines_q} + 6'h01;

   // Single-byte mode settings, kept across power save
   always_ff @(posedge clk) begin
      if (reset) begin
         display_on <= 1'b0;
         seg_reverse <= 1'b0;
         pixel_invert <= 1'b0;
         all_dots_on <= 1'b0;
         bias_low <= 1'b0;
         common_reverse <= 1'b0;
         line_reversal <= 1'b0;
         supply_ctrl <= 3'h0;
      end else if (soft_rst) begin
         common_reverse <= 1'b0;
      end else if (free) begin
         if (c[7:1] == CMD_DISP_OFF[7:1]) display_on <= c[BIT_SEL];
         if (c[7:1] == CMD_ADC[7:1]) seg_reverse <= c[BIT_SEL];
         if (c[7:1] == CMD_INVERT[7:1]) pixel_invert <= c[BIT_SEL];
         if (c[7:1] == CMD_ALLON[7:1]) all_dots_on <= c[BIT_SEL];
         if (c[7:1] == CMD_BIAS[7:1]) bias_low <= c[BIT_SEL];
         if (c[7:4] == PFX_COM[4:1]) common_reverse <= c[BIT_DIR];
         if (c[7:4] == PFX_DRIVE[4:1]) line_reversal <= c[BIT_DIR];
         if (c[7:3] == PFX_PWR) supply_ctrl <= c[2:0];
      end
   end

   // Address settings and resistor ratio
   always_ff @(posedge clk) begin
      if (reset || soft_rst) begin
         start_line <= RST_START;
         mem_page <= RST_PAGE;
         resistor_ratio <= RST_RES;
      end else if (free) begin
         if (c[7:6] == PFX_START) start_line <= c[5:0];
         if (c[7:4] == PFX_PAGE) mem_page <= c[3:0];
         if (c[7:3] == PFX_RES) resistor_ratio <= c[2:0];
      end
   end

   // Column address, nibble writes and read-modify-write stepping
   always_ff @(posedge clk) begin
      if (reset || soft_rst) begin
         col_q <= RST_COL[COL_W-1:0];
         rmw_col_q <= RST_COL[COL_W-1:0];
         rmw_q <= 1'b0;
      end else if (free && c[7:4] == PFX_COL_HI) begin
         col_q <= {c[3:0], col_q[3:0]};
      end else if (free && c[7:4] == PFX_COL_LO) begin
         col_q <= {col_q[7:4], c[3:0]};
      end else if (free && c == CMD_RMW) begin
         rmw_q <= 1'b1;
         rmw_col_q <= col_q;
      end else if (free && c == CMD_END) begin
         rmw_q <= 1'b0;
         col_q <= rmw_col_q;
      end else if (wr_stb && cmd_data_select) begin
         col_q <= col_q + COL_W'(1);
      end else if (rd_stb && cmd_data_select && !rmw_q) begin
         col_q <= col_q + COL_W'(1);
      end
   end
   assign mem_col = col_q;

   // Power save entry, exit and reset-to-sleep
   always_ff @(posedge clk) begin
      if (reset) begin
         pwr_q <= LCD_RUN;
      end else if (free) begin
         if (c == (CMD_ALLON | 8'h01) && !display_on && pwr_q == LCD_RUN) begin
            pwr_q <= ind_en_q ? LCD_STANDBY : LCD_SLEEP;
         end else if (c == CMD_ALLON) begin
            pwr_q <= LCD_RUN;
         end else if (c == CMD_RST && pwr_q == LCD_STANDBY) begin
            pwr_q <= LCD_SLEEP;
         end
      end
   end

   // Power state outputs
   assign standby = pwr_q == LCD_STANDBY;
   assign sleep = pwr_q == LCD_SLEEP;
   assign osc_enable = !sleep;
   assign supply_enable = pwr_q == LCD_RUN;
   assign dynamic_drive_enable = pwr_q == LCD_RUN;
   assign outputs_grounded = pwr_q != LCD_RUN;

   // Factory test mode entry and exit
   always_ff @(posedge clk) begin
      if (reset) begin
         test_mode <= 1'b0;
      end else if (cmd_wr && lock_q == LCD_FREE) begin
         if (test_mode && (c == CMD_NOP || c == CMD_RST)) begin
            test_mode <= 1'b0;
         end else if (c[7:4] == PFX_TEST && test_pin_s) begin
            test_mode <= 1'b1;
         end
      end
   end

   // Memory port works in every power state
   assign mem_wr = wr_stb && cmd_data_select;
   assign mem_rd = rd_stb && cmd_data_select;
   always_ff @(posedge clk) begin
      if (reset) begin
         mem_wr_data <= 8'h00;
      end else if (wr_stb && cmd_data_select) begin
         mem_wr_data <= wr_data;
      end
   end

   // Read answer: status nibble or memory data, one cycle after the strobe
   always_ff @(posedge clk) begin
      if (reset) begin
         rd_data <= 8'h00;
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= rd_stb;
         if (rd_stb && !cmd_data_select) begin
            rd_data <= {rmw_q, !display_on, soft_rst, pwr_q != LCD_RUN, 4'h0};
         end else if (rd_stb) begin
            rd_data <= mem_rd_data;
         end
      end
   end
endmodule
`default_nettype wire

// *** tb/lcd_cmd_decoder_asserts.sv ***
// Concurrent checks of the command decoder port behaviour
`timescale 1ns/100ps
`default_nettype none
module lcd_cmd_chk (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Host bus and memory port
   input wire logic cmd_data_select,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic [7:0] wr_data,
   input wire logic [7:0] rd_data,
   input wire logic rd_valid,
   input wire logic [7:0] mem_rd_data,
   input wire logic mem_wr,
   input wire logic mem_rd,
   // Settings
   input wire logic display_on,
   input wire logic all_dots_on,
   input wire logic [5:0] start_line,
   input wire logic common_reverse,
   input wire logic line_reversal,
   input wire logic [5:0] reversed_lines,
   input wire logic [1:0] indicator_mode,
   // Power and test
   input wire logic osc_enable,
   input wire logic supply_enable,
   input wire logic dynamic_drive_enable,
   input wire logic outputs_grounded,
   input wire logic standby,
   input wire logic sleep,
   input wire logic test_mode
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   logic lock_q;
   logic [7:0] lock_byte_q;
   logic cmd_wr;
   logic cmd_ok;
   // Command strobes, and those free to decode
   assign cmd_wr = wr_stb && !cmd_data_select;
   assign cmd_ok = cmd_wr && !lock_q && !test_mode;
   // Follows the lock opened by a two-byte command; the lock byte is the last command seen
   always_ff @(posedge clk) begin
      if (reset) begin
         lock_q <= 1'b0;
         lock_byte_q <= 8'h00;
      end else if (cmd_wr) begin
         lock_q <= cmd_ok && (wr_data == 8'hAD || wr_data[7:3] == 5'h1B || wr_data == 8'h81);
         lock_byte_q <= wr_data;
      end
   end
   a_display_onoff: assert property (cmd_ok && wr_data[7:1] == 7'h57 |=> display_on == $past(wr_data[0]))
      else $error("display on/off wrong");
   a_drive_method: assert property (cmd_ok && wr_data[7:4] == 4'hD |=> line_reversal == $past(wr_data[3]))
      else $error("drive method wrong");
   a_lock_refuse: assert property (cmd_wr && lock_q |=> $stable(display_on) && $stable(start_line))
      else $error("command taken while locked");
   a_line_count: assert property (cmd_wr && lock_q && lock_byte_q[7:3] == 5'h1B |=>
      reversed_lines == {1'b0, $past(wr_data[4:0])} + 6'h01) else $error("line count wrong");
   a_indicator_set: assert property (cmd_wr && lock_q && lock_byte_q == 8'hAD |=>
      indicator_mode == $past(wr_data[1:0])) else $error("indicator mode wrong");
   a_save_enter: assert property (cmd_ok && wr_data == 8'hA5 && !display_on && !standby && !sleep |=>
      standby != sleep) else $error("power save not entered");
   a_save_exit: assert property (cmd_ok && wr_data == 8'hA4 |=> !standby && !sleep)
      else $error("power save not left");
   a_sleep_drive: assert property (sleep |-> !osc_enable && !supply_enable && outputs_grounded)
      else $error("sleep outputs wrong");
   a_standby_drive: assert property (standby |-> osc_enable && !supply_enable && !dynamic_drive_enable &&
      outputs_grounded) else $error("standby outputs wrong");
   a_reset_sleep: assert property (cmd_ok && wr_data == 8'hE2 && standby |=> sleep && !standby)
      else $error("reset in standby did not sleep");
   a_status_read: assert property (rd_stb && !cmd_data_select |=> rd_valid && rd_data[3:0] == 4'h0)
      else $error("status low nibble wrong");
   a_memory_read: assert property (rd_stb && cmd_data_select |=> rd_valid && rd_data == $past(mem_rd_data))
      else $error("memory read wrong");
   a_test_exit: assert property (test_mode && cmd_wr && wr_data == 8'hE3 |=> !test_mode)
      else $error("no-op did not leave test");
   a_com_dir: assert property (cmd_ok && wr_data[7:4] == 4'hC |=> common_reverse == $past(wr_data[3]))
      else $error("scan direction wrong");
   a_all_dots: assert property (cmd_ok && wr_data[7:1] == 7'h52 |=> all_dots_on == $past(wr_data[0]))
      else $error("all dots on wrong");
   a_mem_write: assert property (cmd_data_select && wr_stb |-> mem_wr)
      else $error("data write missed memory");
   a_cmd_no_mem: assert property (!cmd_data_select |-> !mem_wr && !mem_rd)
      else $error("command reached memory");
   // Main scenarios reached
   c_standby: cover property (standby ##1 sleep);
   c_test: cover property (test_mode);
   c_line_lock: cover property (cmd_wr && lock_q && lock_byte_q[7:3] == 5'h1B);
endmodule
bind lcd_cmd_decoder lcd_cmd_chk i_chk (.clk, .reset, .cmd_data_select, .wr_stb, .rd_stb, .wr_data, .rd_data,
   .rd_valid, .mem_rd_data, .mem_wr, .mem_rd, .display_on, .all_dots_on, .start_line, .common_reverse,
   .line_reversal, .reversed_lines,
   .indicator_mode, .osc_enable, .supply_enable, .dynamic_drive_enable, .outputs_grounded, .standby, .sleep,
   .test_mode);
`default_nettype wire

// *** tb/lcd_host_model.sv ***
// Host processor model issuing command and display data transfers
`timescale 1ns/100ps
`default_nettype none
module lcd_host_model (
   // Clock
   input wire logic clk,
   // Host bus towards the decoder
   output logic cmd_data_select,
   output logic wr_stb,
   output logic rd_stb,
   output logic [7:0] wr_data,
   input wire logic [7:0] rd_data,
   input wire logic rd_valid
);
   // Idle bus at time zero
   initial begin
      cmd_data_select = 1'b0;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      wr_data = 8'h00;
   end
   // One write strobe; the data lines are scrambled once released
   task automatic put(input logic sel, input logic [7:0] d);
      @(posedge clk);
      cmd_data_select <= sel;
      wr_data <= d;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
      wr_data <= ~d;
      @(negedge clk);
   endtask
   // One read strobe; the answer is taken a cycle later
   task automatic get(input logic sel, output logic [7:0] d, output logic v);
      @(posedge clk);
      cmd_data_select <= sel;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      @(negedge clk);
      d = rd_data;
      v = rd_valid;
   endtask
   // Two-byte command: the data byte follows the lock byte after one idle cycle
   task automatic pair(input logic [7:0] c, input logic [7:0] d);
      put(1'b0, c);
      put(1'b0, d);
   endtask
endmodule
`default_nettype wire

// *** tb/test_lcd_driver_command_decoder.sv ***
// Self-checking bench of the LCD command decoder driven by the host model
`timescale 1ns/100ps
`default_nettype none
module test_lcd_driver_command_decoder;
   import lcd_pkg::*;
   logic clk, reset, cmd_data_select, wr_stb, rd_stb, rd_valid, factory_test_enable_pin;
   logic [7:0] wr_data, rd_data, mem_rd_data, mem_wr_data, mem_col, r, d;
   logic [3:0] mem_page, bit0_outs;
   logic [5:0] start_line, reversed_lines, contrast;
   logic [2:0] supply_ctrl, resistor_ratio;
   logic [1:0] indicator_mode;
   logic display_on, seg_reverse, pixel_invert, all_dots_on, bias_low, common_reverse, line_reversal, v;
   logic osc_enable, supply_enable, dynamic_drive_enable, outputs_grounded, standby, sleep, test_mode, indicator_drive;
   logic [7:0] codes [4] = '{CMD_DISP_OFF, CMD_ADC, CMD_INVERT, CMD_BIAS};
   logic [7:0] counts [3] = '{8'hAF, 8'hFF, 8'hE0};
   int mismatches = 0;
   int total_checks = 0;
   int cycles = 0;
   int k;
   assign bit0_outs = {bias_low, pixel_invert, seg_reverse, display_on};
   lcd_host_model i_host (.clk, .cmd_data_select, .wr_stb, .rd_stb, .wr_data, .rd_data, .rd_valid);
   lcd_cmd_decoder #(.SLOW_CYC(8), .FAST_CYC(4)) i_dut (.clk, .reset, .cmd_data_select, .wr_stb, .rd_stb,
      .wr_data, .rd_data, .rd_valid, .factory_test_enable_pin, .mem_rd_data, .mem_wr(), .mem_rd(), .mem_wr_data,
      .mem_page, .mem_col, .display_on, .start_line, .seg_reverse, .pixel_invert, .all_dots_on, .bias_low,
      .common_reverse, .line_reversal, .reversed_lines, .supply_ctrl, .resistor_ratio, .contrast, .osc_enable,
      .supply_enable, .dynamic_drive_enable, .outputs_grounded, .standby, .sleep, .test_mode, .indicator_mode,
      .indicator_drive);
   // Clock at 125 MHz
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Comparison with mismatch report
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   // Expected reversed line count for a count byte
   function automatic logic [7:0] exp_lines(input logic [7:0] b);
      return {3'h0, b[4:0]} + 8'h01;
   endfunction
   // Command byte write
   task automatic w(input logic [7:0] c);
      i_host.put(1'b0, c);
   endtask
   // Verdict and end of run
   task automatic end_of_test;
      if (mismatches == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Hang guard
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         end_of_test();
      end
   end
   // Main sequence
   initial begin
      reset = 1'b1;
      factory_test_enable_pin = 1'b0;
      mem_rd_data = 8'h00;
      r = 8'($urandom(32'h10B1290A));
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      @(negedge clk);
      chk("contrast", 8'h20, {2'h0, contrast});
      for (int i = 0; i < 12; i++) begin
         k = i % 4;
         r = 8'($urandom());
         w(codes[k] | {7'h00, r[0]});
         chk("bit0 setting", {7'h00, r[0]}, {7'h00, bit0_outs[k]});
      end
      r = 8'($urandom());
      w({2'h1, r[5:0]});
      chk("start_line", {2'h0, r[5:0]}, {2'h0, start_line});
      w({4'hB, r[3:0]});
      chk("mem_page", {4'h0, r[3:0]}, {4'h0, mem_page});
      w({4'h1, r[7:4]});
      w({4'h0, r[3:0]});
      chk("mem_col", r, mem_col);
      w({5'h05, r[2:0]});
      chk("supply_ctrl", {5'h00, r[2:0]}, {5'h00, supply_ctrl});
      w({5'h04, r[6:4]});
      chk("resistor_ratio", {5'h00, r[6:4]}, {5'h00, resistor_ratio});
      i_host.pair(CMD_EPOT, r);
      chk("contrast set", {2'h0, r[5:0]}, {2'h0, contrast});
      w({4'hC, r[7], r[2:0]});
      chk("common_reverse", {7'h00, r[7]}, {7'h00, common_reverse});
      w(CMD_DISP_OFF);
      w({5'h1A, r[2:0]});
      chk("frame reversal", 8'h00, {7'h00, line_reversal});
      for (int j = 0; j < 3; j++) begin
         i_host.pair({5'h1B, r[2:0]}, counts[j]);
         chk("line_reversal", 8'h01, {7'h00, line_reversal});
         chk("reversed_lines", exp_lines(counts[j]), {2'h0, reversed_lines});
         chk("locked display_on", 8'h00, {6'h00, test_mode, display_on});
      end
      w(CMD_INVERT);
      i_host.pair(8'hAD, 8'hA7);
      chk("indicator_mode", 8'h03, {6'h00, indicator_mode});
      chk("locked pixel_invert", 8'h00, {7'h00, pixel_invert});
      w(8'hA5);
      chk("standby/sleep", 8'h06, {5'h00, all_dots_on, standby, sleep});
      chk("standby drive", 8'h0D, {4'h0, indicator_drive, osc_enable, supply_enable, outputs_grounded});
      i_host.get(1'b0, d, v);
      chk("status", 8'h50, d);
      r = 8'($urandom());
      @(posedge clk);
      mem_rd_data <= r;
      i_host.get(1'b1, d, v);
      chk("memory read", r, d);
      i_host.put(1'b1, ~r);
      chk("mem_wr_data", ~r, mem_wr_data);
      w(CMD_RST);
      chk("sleep drive", 8'h04, {4'h0, standby, sleep, osc_enable, supply_enable});
      w(CMD_ALLON);
      chk("awake", 8'h01, {4'h0, all_dots_on, standby, sleep, line_reversal});
      w(8'hAC);
      w(8'hA5);
      chk("sleep entry", 8'h01, {6'h00, standby, sleep});
      w(CMD_ALLON);
      w(8'h13);
      w(8'h05);
      w(CMD_RMW);
      i_host.get(1'b1, d, v);
      chk("rmw read col", 8'h35, mem_col);
      i_host.get(1'b0, d, v);
      chk("rmw status", 8'hC0, d);
      i_host.put(1'b1, r);
      chk("rmw write col", 8'h36, mem_col);
      w(CMD_END);
      chk("end col", 8'h35, mem_col);
      w(8'hF5);
      chk("test pin low", 8'h00, {7'h00, test_mode});
      @(posedge clk);
      factory_test_enable_pin <= 1'b1;
      repeat (3) @(posedge clk);
      w(8'hF0);
      w(8'hAF);
      chk("test mode", 8'h02, {6'h00, test_mode, display_on});
      w(CMD_NOP);
      chk("test exit", 8'h00, {7'h00, test_mode});
      i_host.put(1'b1, 8'hAF);
      w(8'hE1);
      chk("data not command", 8'h00, {7'h00, display_on});
      w(8'hAF);
      chk("after unknown", 8'h01, {7'h00, display_on});
      end_of_test();
   end
endmodule
`default_nettype wire
